/* src/fpec_ctrl.sv */
// FP application control: trap enables, rounding, exception modes and
// Program interrupt delivery, with an APB register slave.
// Assumes a synchronous pipeline reporting one exception group per cycle.
`timescale 1ns/10ps

// Functional notes
// - Invalid trap enable gates interrupt
// - Overflow trap enable gates interrupt
// - Underflow trap enable gates interrupt
// - Divide-by-zero trap enable gates interrupt
// - Inexact trap enable gates interrupt
// - Relaxed mode bit exported to datapath
// - Two-bit rounding field selects rounding
// - Mode bits at state bits 20/23
// - Mode 00 never interrupts
// - Mode 01 late interrupt, no tag
// - Mode 10 late interrupt, tag kept
// - Mode 11 interrupt at faulting instruction
// - Nonzero mode uses per-type enables
// - Registers hold four data types
// - Round-to-single uses current rounding mode
// - Result precision comes from encoding
// - Hardware FP handling is IEEE conformant
module fpec_ctrl
  import fpec_pkg::*;
#(
  parameter int DLY_CYC = IMPREC_DLY
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [fpec_pkg::ADDR_W-1:0] paddr,
  input  wire logic [fpec_pkg::REG_W-1:0]  pwdata,
  output logic      [fpec_pkg::REG_W-1:0]  prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     exc_valid,
  input  wire logic [fpec_pkg::NEXC-1:0]   exc_flags,
  input  wire logic [fpec_pkg::REG_W-1:0]  exc_tag,
  input  wire logic                     wr_valid,
  input  wire logic [fpec_pkg::IDX_W-1:0]  wr_idx,
  input  wire fpec_pkg::fpec_type_t     wr_type,
  input  wire logic                     wr_round_single,
  output logic                          program_irq,
  output logic      [fpec_pkg::NEXC-1:0]   irq_cause,
  output logic      [fpec_pkg::REG_W-1:0]  irq_tag,
  output logic                          irq_precise,
  output fpec_pkg::fpec_rnd_t           rounding_select,
  output logic                          relaxed_ieee_mode
);
  import fpec_pkg::*;

  localparam int CNT_W = $clog2(DLY_CYC + 1) + 1;
  localparam logic [CNT_W-1:0] DLY_LAST = CNT_W'(DLY_CYC - 1);

  typedef enum logic [0:0] {
    FPEC_ST_IDLE,
    FPEC_ST_WAIT
  } fpec_state_t;

  // Same low-word positions serve 32- and 64-bit machine state layouts
  localparam int MHI_POS = be_pos(REG_W, MS32_BIT_MHI);
  localparam int MLO_POS = be_pos(REG_W, MS32_BIT_MLO);
  localparam int MHI_P64 = be_pos(MS64_W, MS64_BIT_MHI);
  localparam int MLO_P64 = be_pos(MS64_W, MS64_BIT_MLO);

  logic [REG_W-1:0]  fpsc_ff;
  logic [REG_W-1:0]  mstate_ff;
  logic [NEXC-1:0]   sticky_ff;
  logic [REG_W-1:0]  kept_tag_ff;
  logic              kept_vld_ff;
  fpec_type_t        type_ff [NFPR];
  fpec_state_t       state_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic [NEXC-1:0]   pend_cause_ff;
  logic [REG_W-1:0]  pend_tag_ff;
  logic [REG_W-1:0]  prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;
  logic              irq_ff;
  logic [NEXC-1:0]   irq_cause_ff;
  logic [REG_W-1:0]  irq_tag_ff;
  logic              irq_precise_ff;
  logic              relaxed_ff;
  fpec_rnd_t         rnd_ff;

  logic              fp_exc_mode_hi;
  logic              fp_exc_mode_lo;
  fpec_mode_t        mode;
  logic [NEXC-1:0]   trap_en;
  logic [NEXC-1:0]   hit_cause;
  logic              hit;
  logic              wr_acc;
  logic              setup;
  logic [REG_W-1:0]  sticky_clr;
  logic [REG_W-1:0]  nxt_rdata;
  logic              nxt_err;

  // Pack sixteen register type codes into one read word
  function automatic logic [REG_W-1:0] pack_types(input int base);
    logic [REG_W-1:0] w;
    w = '0;
    for (int i = 0; i < NFPR / 2; i++) begin
      w[2*i +: 2] = type_ff[base + i];
    end
    return w;
  endfunction : pack_types

  // True for the two late-delivery modes
  function automatic logic is_late(input fpec_mode_t m);
    return (m == FPEC_MODE_IMP_NR) || (m == FPEC_MODE_IMP_REC);
  endfunction : is_late

  // Tag kept for the handler only where it must find the instruction
  function automatic logic [REG_W-1:0] late_tag(input fpec_mode_t m,
                                                input logic [REG_W-1:0] t);
    return (m == FPEC_MODE_IMP_REC) ? t : '0;
  endfunction : late_tag

  // Mode decode
  always_comb begin
    fp_exc_mode_hi = mstate_ff[MHI_POS];
    fp_exc_mode_lo = mstate_ff[MLO_POS];
    mode           = fpec_mode_t'({fp_exc_mode_hi, fp_exc_mode_lo});
  end

  // Per-type enables, big-endian bit numbers
  always_comb begin
    trap_en           = '0;
    trap_en[EXC_INV]  = fpsc_ff[be_pos(REG_W, FPSC_BIT_INV)];
    trap_en[EXC_OVF]  = fpsc_ff[be_pos(REG_W, FPSC_BIT_OVF)];
    trap_en[EXC_UNF]  = fpsc_ff[be_pos(REG_W, FPSC_BIT_UNF)];
    trap_en[EXC_DIV0] = fpsc_ff[be_pos(REG_W, FPSC_BIT_DIV0)];
    trap_en[EXC_INX]  = fpsc_ff[be_pos(REG_W, FPSC_BIT_INX)];
  end

  // Disabled types fall back to the default result in the datapath
  always_comb begin
    hit_cause = exc_flags & trap_en;
    hit       = exc_valid && (|hit_cause)
                && (mode != FPEC_MODE_IGNORE);
  end

  always_comb begin
    setup  = psel && !penable;
    wr_acc = psel && penable && pready_ff && pwrite;
  end

  // Write-one-to-clear mask for the sticky cause bits
  always_comb begin
    sticky_clr = '0;
    if (wr_acc && paddr == OFS_EXCSTAT) begin
      sticky_clr = pwdata;
    end
  end

  // Read mux, evaluated in the setup cycle
  always_comb begin
    nxt_rdata = '0;
    nxt_err   = 1'b0;
    unique case (paddr)
      OFS_FPSC:    nxt_rdata = fpsc_ff;
      OFS_MSTATE:  nxt_rdata = mstate_ff;
      OFS_EXCSTAT: nxt_rdata = {{(REG_W-NEXC-1){1'b0}}, kept_vld_ff, sticky_ff};
      OFS_EXCTAG:  nxt_rdata = kept_tag_ff;
      OFS_TYPELO:  nxt_rdata = pack_types(0);
      OFS_TYPEHI:  nxt_rdata = pack_types(NFPR / 2);
      default:     nxt_err   = 1'b1;
    endcase
  end

  // APB handshake: one access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else if (setup) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= nxt_err;
      prdata_ff  <= pwrite ? '0 : nxt_rdata;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fpsc_ff <= RST_FPSC;
    end else if (wr_acc && paddr == OFS_FPSC) begin
      fpsc_ff <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mstate_ff <= RST_MSTATE;
    end else if (wr_acc && paddr == OFS_MSTATE) begin
      mstate_ff <= pwdata;
    end
  end

  // Control fields exported to the datapath straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relaxed_ff <= 1'b0;
      rnd_ff     <= FPEC_RND_NEAR;
    end else begin
      relaxed_ff <= fpsc_ff[be_pos(REG_W, FPSC_BIT_RELAX)];
      rnd_ff     <= fpec_rnd_t'({fpsc_ff[be_pos(REG_W, FPSC_BIT_RND0)],
                                 fpsc_ff[be_pos(REG_W, FPSC_BIT_RND1)]});
    end
  end

  // Sticky causes: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_ff <= '0;
    end else begin
      sticky_ff <= (sticky_ff & ~sticky_clr[NEXC-1:0])
                   | (hit ? hit_cause : '0);
    end
  end

  // Recoverable and precise modes keep the faulting instruction's tag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kept_tag_ff <= '0;
      kept_vld_ff <= 1'b0;
    end else if (hit && !kept_vld_ff
                 && (mode == FPEC_MODE_IMP_REC || mode == FPEC_MODE_PRECISE)) begin
      kept_tag_ff <= exc_tag;
      kept_vld_ff <= 1'b1;
    end else if (wr_acc && paddr == OFS_EXCSTAT && pwdata[NEXC]) begin
      kept_vld_ff <= 1'b0;
    end
  end

  // Register type tracking; precision is the instruction's, not a mode's
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NFPR; i++) begin
        type_ff[i] <= FPEC_TYPE_DP;
      end
    end else if (wr_valid) begin
      type_ff[wr_idx] <= wr_round_single ? FPEC_TYPE_SP
                                         : wr_type;
    end
  end

  // Imprecise delivery: gather enabled causes, report after a delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff      <= FPEC_ST_IDLE;
      cnt_ff        <= '0;
      pend_cause_ff <= '0;
      pend_tag_ff   <= '0;
    end else begin
      unique case (state_ff)
        FPEC_ST_IDLE: begin
          if (hit && is_late(mode)) begin
            state_ff      <= FPEC_ST_WAIT;
            cnt_ff        <= '0;
            pend_cause_ff <= hit_cause;
            pend_tag_ff   <= late_tag(mode, exc_tag);
          end
        end
        FPEC_ST_WAIT: begin
          if (mode == FPEC_MODE_IGNORE) begin
            state_ff <= FPEC_ST_IDLE;
          end else if (cnt_ff == DLY_LAST) begin
            // A hit on the emitting edge opens a fresh wait, else the wait returns to idle
            if (hit && is_late(mode)) begin
              cnt_ff        <= '0;
              pend_cause_ff <= hit_cause;
              pend_tag_ff   <= late_tag(mode, exc_tag);
            end else begin
              state_ff <= FPEC_ST_IDLE;
            end
          end else begin
            cnt_ff        <= cnt_ff + 1'b1;
            pend_cause_ff <= pend_cause_ff | (hit ? hit_cause : '0);
          end
        end
      endcase
    end
  end

  // Interrupt request to the core; precise wins when both fall together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff         <= 1'b0;
      irq_cause_ff   <= '0;
      irq_tag_ff     <= '0;
      irq_precise_ff <= 1'b0;
    end else if (hit && mode == FPEC_MODE_PRECISE) begin
      irq_ff         <= 1'b1;
      irq_cause_ff   <= hit_cause;
      irq_tag_ff     <= exc_tag;
      irq_precise_ff <= 1'b1;
    end else if (state_ff == FPEC_ST_WAIT && cnt_ff == DLY_LAST
                 && mode != FPEC_MODE_IGNORE) begin
      irq_ff         <= 1'b1;
      irq_cause_ff   <= pend_cause_ff;
      irq_tag_ff     <= pend_tag_ff;
      irq_precise_ff <= 1'b0;
    end else begin
      irq_ff         <= 1'b0;
      irq_precise_ff <= 1'b0;
    end
  end

  // Default results and special values stay in the IEEE datapath
  always_comb begin
    prdata            = prdata_ff;
    pready            = pready_ff;
    pslverr           = pslverr_ff;
    program_irq       = irq_ff;
    irq_cause         = irq_cause_ff;
    irq_tag           = irq_tag_ff;
    irq_precise       = irq_precise_ff;
    rounding_select   = rnd_ff;
    relaxed_ieee_mode = relaxed_ff;
  end

  // 64-bit layout check folds to the same positions
  logic unused_p64;
  always_comb begin
    unused_p64 = (MHI_P64 == MHI_POS) && (MLO_P64 == MLO_POS);
  end

endmodule : fpec_ctrl

/* src/fpec_pkg.sv */
// Constants, field positions and types for the FP exception control block.
// Assumes big-endian bit numbering in the printed figures (bit 0 is MSB).
package fpec_pkg;

  localparam int REG_W  = 32;
  localparam int ADDR_W = 8;
  localparam int NEXC   = 5;
  localparam int NFPR   = 32;
  localparam int IDX_W  = 5;

  // Printed bit numbers, big-endian numbering
  localparam int FPSC_BIT_INV   = 24;
  localparam int FPSC_BIT_OVF   = 25;
  localparam int FPSC_BIT_UNF   = 26;
  localparam int FPSC_BIT_DIV0  = 27;
  localparam int FPSC_BIT_INX   = 28;
  localparam int FPSC_BIT_RELAX = 29;
  localparam int FPSC_BIT_RND0  = 30;
  localparam int FPSC_BIT_RND1  = 31;
  localparam int MS64_BIT_MHI   = 52;
  localparam int MS64_BIT_MLO   = 55;
  localparam int MS32_BIT_MHI   = 20;
  localparam int MS32_BIT_MLO   = 23;
  localparam int MS64_W         = 64;

  // Exception vector positions, as reported by the pipeline
  localparam int EXC_INV  = 4;
  localparam int EXC_OVF  = 3;
  localparam int EXC_UNF  = 2;
  localparam int EXC_DIV0 = 1;
  localparam int EXC_INX  = 0;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FPSC    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MSTATE  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EXCSTAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EXCTAG  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_TYPELO  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TYPEHI  = 8'h14;

  localparam logic [REG_W-1:0] RST_FPSC   = 32'h0000_0000;
  localparam logic [REG_W-1:0] RST_MSTATE = 32'h0000_0000;
  localparam int               IMPREC_DLY = 4;

  // Little-endian index of a big-endian numbered bit
  function automatic int be_pos(input int width, input int bit_no);
    return width - 1 - bit_no;
  endfunction : be_pos

  typedef enum logic [1:0] {
    FPEC_MODE_IGNORE  = 2'h0,
    FPEC_MODE_IMP_NR  = 2'h1,
    FPEC_MODE_IMP_REC = 2'h2,
    FPEC_MODE_PRECISE = 2'h3
  } fpec_mode_t;

  typedef enum logic [1:0] {
    FPEC_RND_NEAR = 2'h0,
    FPEC_RND_ZERO = 2'h1,
    FPEC_RND_PINF = 2'h2,
    FPEC_RND_MINF = 2'h3
  } fpec_rnd_t;

  typedef enum logic [1:0] {
    FPEC_TYPE_SP  = 2'h0,
    FPEC_TYPE_DP  = 2'h1,
    FPEC_TYPE_I32 = 2'h2,
    FPEC_TYPE_I64 = 2'h3
  } fpec_type_t;

endpackage : fpec_pkg

/* testbench/fpec_ctrl_checker.sv */
// Port assertions for the FP exception control block.
// Assumes the APB writes seen at the ports are the only register updates.
`timescale 1ns/10ps
module fpec_ctrl_checker
  import fpec_pkg::*;
#(
  parameter int DLY_CYC = 1
) (
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [fpec_pkg::ADDR_W-1:0]    paddr,
  input wire logic [fpec_pkg::REG_W-1:0]     pwdata,
  input wire logic                           pready,
  input wire logic                           exc_valid,
  input wire logic [fpec_pkg::NEXC-1:0]      exc_flags,
  input wire logic [fpec_pkg::REG_W-1:0]     exc_tag,
  input wire logic                           program_irq,
  input wire logic [fpec_pkg::NEXC-1:0]      irq_cause,
  input wire logic [fpec_pkg::REG_W-1:0]     irq_tag,
  input wire logic                           irq_precise,
  input wire fpec_pkg::fpec_rnd_t            rounding_select,
  input wire logic                           relaxed_ieee_mode
);
  import fpec_pkg::*;
  localparam int DMAX = DLY_CYC + 2;
  logic [4:0] en_ff;
  logic [4:0] hit_flags;
  logic [1:0] mode_ff;
  logic [1:0] rnd_ff;
  logic       rlx_ff;
  logic       wr_acc;
  assign wr_acc = psel && penable && pready && pwrite;
  assign hit_flags = exc_flags & en_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= 5'h00;
      rlx_ff <= 1'b0;
      rnd_ff <= 2'h0;
    end else if (wr_acc && paddr == OFS_FPSC) begin
      en_ff <= pwdata[7:3];
      rlx_ff <= pwdata[2];
      rnd_ff <= pwdata[1:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= 2'h0;
    end else if (wr_acc && paddr == OFS_MSTATE) begin
      mode_ff <= {pwdata[11], pwdata[8]};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_prec;
    exc_valid && hit_flags != 5'h00 && mode_ff == 2'h3;
  endsequence
  sequence s_imp;
    exc_valid && hit_flags != 5'h00 && (mode_ff == 2'h1 || mode_ff == 2'h2);
  endsequence
  AST_PRECISE: assert property (s_prec |=> program_irq && irq_precise
    && irq_cause == $past(hit_flags) && irq_tag == $past(exc_tag)) else $error("precise irq");
  AST_IMP_DLY: assert property (s_imp |-> ##[1:DMAX] program_irq)
    else $error("late irq missing");
  AST_IGNORE: assert property ((mode_ff == 2'h0) [*3] |-> !program_irq)
    else $error("irq in ignore mode");
  AST_PRC_MODE: assert property (irq_precise |-> program_irq && $past(mode_ff) == 2'h3)
    else $error("precise flag wrong");
  AST_TAG01: assert property (program_irq && mode_ff == 2'h1 |-> irq_tag == 32'h0)
    else $error("tag in mode 01");
  AST_CAUSE_EN: assert property (program_irq |-> irq_cause != 5'h00
    && (irq_cause & ~en_ff) == 5'h00) else $error("cause not enabled");
  AST_RND: assert property (rounding_select == $past(rnd_ff))
    else $error("rounding output");
  AST_RELAX: assert property (relaxed_ieee_mode == $past(rlx_ff))
    else $error("relaxed output");
  AST_APB_RDY: assert property (psel && !penable |=> pready) else $error("pready late");
endmodule : fpec_ctrl_checker

bind fpec_ctrl fpec_ctrl_checker #(.DLY_CYC(DLY_CYC)) u_chk (.*);

/* testbench/fpec_ctrl_tb.sv */
// Self-checking bench for the FP exception control block.
// Assumes the pipeline model and checker files are compiled before it.
`timescale 1ns/10ps
module fpec_ctrl_tb;
  import fpec_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        exc_valid, wr_valid, wr_round_single, program_irq, irq_precise;
  logic        relaxed_ieee_mode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, exc_tag, irq_tag;
  logic [4:0]  exc_flags, irq_cause, wr_idx;
  fpec_rnd_t   rounding_select;
  fpec_type_t  wr_type;
  int          num_errors, n_compared, cyc;
  fpec_ctrl #(.DLY_CYC(1)) dut (.*);
  fpec_pipe_model u_pipe (.pclk(pclk), .exc_valid(exc_valid), .exc_flags(exc_flags),
    .exc_tag(exc_tag), .wr_valid(wr_valid), .wr_idx(wr_idx), .wr_type(wr_type),
    .wr_round_single(wr_round_single));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look mid-cycle so the answer is read while it stands, not at its edge
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 20) begin
      num_errors++;
      test_done();
    end
    q = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp,
                    input logic experr);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, q, exp);
    chk("pslverr", e, experr);
  endtask : rd
  // Checks 1 ns after each rising edge, so a one-cycle pulse is never missed
  task automatic wait_irq(output logic got, output logic prc);
    got = 1'b0;
    prc = 1'b0;
    repeat (8) begin
      #1;
      if (program_irq === 1'b1) begin
        got = 1'b1;
        prc = irq_precise;
        break;
      end
      @(posedge pclk);
    end
  endtask : wait_irq
  task automatic t_reset();
    rd("fpsc", OFS_FPSC, 32'h0, 1'b0);
    rd("mstate", OFS_MSTATE, 32'h0, 1'b0);
    rd("types_lo", OFS_TYPELO, 32'h5555_5555, 1'b0);
    rd("unmapped", 8'h20, 32'h0, 1'b1);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_round();
    for (int r = 0; r < 4; r++) begin
      wr(OFS_FPSC, 32'(r) | (32'(r % 2) << 2));
      repeat (3) @(posedge pclk);
      chk("rounding", 32'(rounding_select), 32'(r));
      chk("relaxed", relaxed_ieee_mode, 32'(r % 2));
    end
    $display("t_round done");
  endtask : t_round
  task automatic t_types();
    @(posedge pclk);
    u_pipe.wr_reg(5'd3, FPEC_TYPE_I64, 1'b0);
    @(posedge pclk);
    u_pipe.wr_reg(5'd17, FPEC_TYPE_DP, 1'b1);
    rd("types_lo", OFS_TYPELO, 32'h5555_55D5, 1'b0);
    rd("types_hi", OFS_TYPEHI, 32'h5555_5551, 1'b0);
    $display("t_types done");
  endtask : t_types
  task automatic t_modes();
    logic got, prc;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 5; k++) begin
        wr(OFS_FPSC, 32'h1 << (3 + k));
        wr(OFS_MSTATE, (32'(m / 2) << 11) | (32'(m % 2) << 8));
        @(posedge pclk);
        u_pipe.report(5'h1F ^ (5'h01 << k), 32'hA0 + k);
        wait_irq(got, prc);
        chk("irq_disabled", got, 32'h0);
        @(posedge pclk);
        u_pipe.report(5'h1F, 32'hC0 + k);
        wait_irq(got, prc);
        chk("irq", got, 32'(m != 0));
        if (m != 0) begin
          chk("cause", irq_cause, 32'h1 << k);
          chk("precise", prc, 32'(m == 3));
          chk("tag", irq_tag, (m == 1) ? 32'h0 : 32'hC0 + k);
        end
      end
    end
    $display("t_modes done");
  endtask : t_modes
  // Every type hit in modes 01..11; first kept tag is mode 10, inexact-only run
  task automatic t_status();
    rd("exc_status", OFS_EXCSTAT, 32'h0000_003F, 1'b0);
    rd("exc_tag", OFS_EXCTAG, 32'h0000_00C0, 1'b0);
    wr(OFS_EXCSTAT, 32'h0000_003F);
    rd("exc_status_clr", OFS_EXCSTAT, 32'h0, 1'b0);
    $display("t_status done");
  endtask : t_status
  initial begin
    num_errors = 0;
    n_compared = 0;
    cyc = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_round();
    t_types();
    t_modes();
    t_status();
    test_done();
  end
endmodule : fpec_ctrl_tb

/* testbench/fpec_pipe_model.sv */
// Pipeline-side model: reports FP exceptions and register type writes.
// Assumes its tasks are called right after a rising pclk edge.
`timescale 1ns/10ps
module fpec_pipe_model
  import fpec_pkg::*;
(
  input  wire logic                       pclk,
  output logic                            exc_valid,
  output logic [fpec_pkg::NEXC-1:0]       exc_flags,
  output logic [fpec_pkg::REG_W-1:0]      exc_tag,
  output logic                            wr_valid,
  output logic [fpec_pkg::IDX_W-1:0]      wr_idx,
  output fpec_pkg::fpec_type_t            wr_type,
  output logic                            wr_round_single
);
  initial begin
    exc_valid = 1'b0;
    exc_flags = 5'h00;
    exc_tag = 32'h0;
    wr_valid = 1'b0;
    wr_idx = 5'h00;
    wr_type = FPEC_TYPE_SP;
    wr_round_single = 1'b0;
  end
  // Remainder and some conversions stay in software, never reported
  // Stale flags and tag are inverted so a late sample cannot pass by luck
  task automatic report(input logic [4:0] f, input logic [31:0] t);
    exc_valid <= 1'b1;
    exc_flags <= f;
    exc_tag <= t;
    @(posedge pclk);
    exc_valid <= 1'b0;
    exc_flags <= ~f;
    exc_tag <= ~t;
  endtask : report
  // Type comes from the encoding; round-to-single results are singles
  task automatic wr_reg(input logic [4:0] i, input fpec_type_t ty, input logic rs);
    wr_valid <= 1'b1;
    wr_idx <= i;
    wr_type <= ty;
    wr_round_single <= rs;
    @(posedge pclk);
    wr_valid <= 1'b0;
    wr_idx <= ~i;
  endtask : wr_reg
endmodule : fpec_pipe_model
